// File: fsel_pkg.sv
// Constants and types shared by the file selection command decoder.
package fsel_pkg;

   // Selection method carried in P1.
   localparam logic [7:0] P1_BY_FID    = 8'h00;
   localparam logic [7:0] P1_CHILD_DF  = 8'h01;
   localparam logic [7:0] P1_PARENT_DF = 8'h03;
   localparam logic [7:0] P1_BY_NAME   = 8'h04;
   localparam logic [7:0] P1_PATH_MF   = 8'h08;
   localparam logic [7:0] P1_PATH_CUR  = 8'h09;

   // Field positions inside P2.
   localparam int P2_RFU_BIT  = 7;
   localparam int P2_SESS_MSB = 6;
   localparam int P2_SESS_LSB = 5;
   localparam int P2_RSP_MSB  = 4;
   localparam int P2_RSP_LSB  = 2;
   localparam int P2_OCC_MSB  = 1;
   localparam int P2_OCC_LSB  = 0;

   localparam logic [1:0] SESS_ACTIVATE  = 2'h0;
   localparam logic [1:0] SESS_TERMINATE = 2'h2;
   localparam logic [2:0] RSP_FCP        = 3'h1;
   localparam logic [2:0] RSP_NONE       = 3'h3;

   // Template tags.
   localparam logic [7:0] TAG_FCP     = 8'h62;
   localparam logic [7:0] TAG_LEN_EXT = 8'h81;
   localparam logic [7:0] TAG_DESC    = 8'h82;
   localparam logic [7:0] TAG_FID     = 8'h83;
   localparam logic [7:0] TAG_NAME    = 8'h84;
   localparam logic [7:0] TAG_PROP    = 8'hA5;
   localparam logic [7:0] TAG_LCS     = 8'h8A;
   localparam logic [7:0] TAG_SEC_A   = 8'h8B;
   localparam logic [7:0] TAG_SEC_B   = 8'h8C;
   localparam logic [7:0] TAG_SEC_C   = 8'hAB;
   localparam logic [7:0] TAG_PIN     = 8'hC6;
   localparam logic [7:0] TAG_TOTAL   = 8'h81;
   localparam logic [7:0] TAG_SIZE    = 8'h80;
   localparam logic [7:0] TAG_SFI     = 8'h88;

   localparam logic [7:0] SHORT_LEN_MAX = 8'h7F;

   // Status words.
   localparam logic [15:0] SW_OK        = 16'h9000;
   localparam logic [15:0] SW_BAD_P1P2  = 16'h6A86;
   localparam logic [15:0] SW_NOT_FOUND = 16'h6A82;
   localparam logic [15:0] SW_BAD_LC    = 16'h6A87;

   localparam int         KEY_BYTES = 16;
   localparam logic [3:0] OBJ_STEPS = 4'h8;
   localparam logic [7:0] MF_REF    = 8'h00;

   typedef enum logic [1:0] {
      CLS_MF  = 2'h0,
      CLS_DF  = 2'h1,
      CLS_ADF = 2'h2,
      CLS_EF  = 2'h3
   } file_class_t;

   typedef enum logic [2:0] {
      SC_CHILD_CUR    = 3'h0,
      SC_PARENT       = 3'h1,
      SC_CHILD_PARENT = 3'h2,
      SC_CHILD_DF     = 3'h3,
      SC_NAME         = 3'h4,
      SC_PATH_MF      = 3'h5,
      SC_PATH_CUR     = 3'h6
   } scope_t;

endpackage

// File: fcp_tag_order.sv
// Tag sequence of the control parameter template for each file class.
module fcp_tag_order (
   input  fsel_pkg::file_class_t file_class,
   input  logic [2:0]            step,
   input  logic [1:0]            sec_sub,
   output logic [7:0]            tag,
   output logic                  is_sec,
   output logic                  skip
);

   logic [7:0] sec_tag;

   always_comb begin
      case (sec_sub)
         2'h0:    sec_tag = fsel_pkg::TAG_SEC_A;
         2'h1:    sec_tag = fsel_pkg::TAG_SEC_B;
         default: sec_tag = fsel_pkg::TAG_SEC_C;
      endcase
   end

   always_comb begin
      tag    = fsel_pkg::TAG_DESC;
      is_sec = 1'b0;
      skip   = 1'b0;
      if (file_class == fsel_pkg::CLS_EF) begin
         case (step)
            3'h0:    tag = fsel_pkg::TAG_DESC;
            3'h1:    tag = fsel_pkg::TAG_FID;
            3'h2:    tag = fsel_pkg::TAG_PROP;
            3'h3:    tag = fsel_pkg::TAG_LCS;
            3'h4: begin
               tag    = sec_tag;
               is_sec = 1'b1;
            end
            3'h5:    tag = fsel_pkg::TAG_SIZE;
            3'h6:    tag = fsel_pkg::TAG_TOTAL;
            default: tag = fsel_pkg::TAG_SFI;
         endcase
      end else begin
         case (step)
            3'h0:    tag = fsel_pkg::TAG_DESC;
            3'h1:    tag = fsel_pkg::TAG_FID;
            3'h2: begin
               tag  = fsel_pkg::TAG_NAME;
               skip = (file_class != fsel_pkg::CLS_ADF);
            end
            3'h3:    tag = fsel_pkg::TAG_PROP;
            3'h4:    tag = fsel_pkg::TAG_LCS;
            3'h5: begin
               tag    = sec_tag;
               is_sec = 1'b1;
            end
            3'h6:    tag = fsel_pkg::TAG_PIN;
            default: tag = fsel_pkg::TAG_TOTAL;
         endcase
      end
   end

endmodule

// File: file_select_command_decoder.sv
// File selection command decoder: parameter checks, search, template build.
module file_select_command_decoder (
   input  logic         CORE_CLK,
   input  logic         RST_N,
   input  logic         CMD_VALID,
   input  logic [7:0]   CMD_P1,
   input  logic [7:0]   CMD_P2,
   input  logic [7:0]   CMD_LC,
   input  logic         CMD_LE_PRESENT,
   input  logic [7:0]   CMD_LE,
   input  logic         DATA_VALID,
   input  logic [7:0]   DATA_BYTE,
   input  logic         LOOKUP_DONE,
   input  logic         LOOKUP_FOUND,
   input  logic [1:0]   LOOKUP_CLASS,
   input  logic [7:0]   LOOKUP_REF,
   input  logic         OBJ_PRESENT,
   input  logic [7:0]   OBJ_LEN,
   input  logic [7:0]   OBJ_BYTE,
   output logic         CMD_BUSY,
   output logic         LOOKUP_REQ,
   output logic [2:0]   LOOKUP_SCOPE,
   output logic [1:0]   LOOKUP_OCC,
   output logic         LOOKUP_PREFIX,
   output logic [127:0] LOOKUP_KEY,
   output logic [4:0]   LOOKUP_KEY_LEN,
   output logic [7:0]   CUR_DIR,
   output logic [7:0]   SEL_FILE,
   output logic [7:0]   OBJ_TAG,
   output logic [7:0]   OBJ_IDX,
   output logic         RSP_VALID,
   output logic [7:0]   RSP_BYTE,
   output logic         SW_VALID,
   output logic [15:0]  SW,
   output logic         SESSION_START,
   output logic         SESSION_END,
   output logic         PTR_INVALIDATE
);

   typedef enum logic [3:0] {
      S_IDLE  = 4'h0,
      S_DATA  = 4'h1,
      S_LOOK  = 4'h3,
      S_LWAIT = 4'h2,
      S_OREQ  = 4'h6,
      S_OWAIT = 4'h7,
      S_OEVAL = 4'h5,
      S_HDR   = 4'h4,
      S_BWAIT = 4'hC,
      S_BYTE  = 4'hD,
      S_STAT  = 4'hF
   } state_t;

   state_t                state_ff, nxt_state;
   logic [7:0]            p1_ff, nxt_p1, p2_ff, nxt_p2, lc_ff, nxt_lc, le_ff, nxt_le;
   logic                  le_pres_ff, nxt_le_pres;
   logic [7:0]            data_cnt_ff, nxt_data_cnt;
   logic [7:0]            key_ff [fsel_pkg::KEY_BYTES];
   logic [7:0]            nxt_key [fsel_pkg::KEY_BYTES];
   logic [1:0]            stage_ff, nxt_stage;
   fsel_pkg::file_class_t cls_ff, nxt_cls;
   logic [7:0]            cur_dir_ff, nxt_cur_dir, sel_ff, nxt_sel;
   logic [3:0]            step_ff, nxt_step;
   logic [1:0]            sec_ff, nxt_sec, hdr_ff, nxt_hdr;
   logic                  pass_ff, nxt_pass;
   logic [8:0]            total_ff, nxt_total, out_cnt_ff, nxt_out_cnt;
   logic [7:0]            olen_ff, nxt_olen, part_ff, nxt_part;
   logic [7:0]            tag_ff, nxt_tag, idx_ff, nxt_idx;
   logic                  req_ff, nxt_req, rsp_v_ff, nxt_rsp_v, sw_v_ff, nxt_sw_v;
   logic [7:0]            rsp_b_ff, nxt_rsp_b;
   logic [15:0]           sw_ff, nxt_sw;
   logic                  ss_ff, nxt_ss, se_ff, nxt_se, inv_ff, nxt_inv;
   logic [2:0]            scope_ff, nxt_scope;
   logic                  busy_ff, pfx_ff;
   logic [1:0]            occ_ff, nxt_occ;

   logic [7:0]            ord_tag;
   logic                  ord_sec, ord_skip, bad_param, commit, emit_en, limited;
   logic [7:0]            emit_byte, c_ref;
   fsel_pkg::file_class_t c_cls;
   logic [1:0]            sess;
   logic [2:0]            rsp_kind;

   fcp_tag_order u_order (
      .file_class (cls_ff),
      .step       (step_ff[2:0]),
      .sec_sub    (sec_ff),
      .tag        (ord_tag),
      .is_sec     (ord_sec),
      .skip       (ord_skip)
   );

   assign sess     = p2_ff[fsel_pkg::P2_SESS_MSB:fsel_pkg::P2_SESS_LSB];
   assign rsp_kind = p2_ff[fsel_pkg::P2_RSP_MSB:fsel_pkg::P2_RSP_LSB];
   assign limited  = le_pres_ff && (le_ff != 8'h00);

   always_comb begin
      bad_param = 1'b0;
      if (!(p1_ff == fsel_pkg::P1_BY_FID || p1_ff == fsel_pkg::P1_CHILD_DF ||
            p1_ff == fsel_pkg::P1_PARENT_DF || p1_ff == fsel_pkg::P1_BY_NAME ||
            p1_ff == fsel_pkg::P1_PATH_MF || p1_ff == fsel_pkg::P1_PATH_CUR)) begin
         bad_param = 1'b1;
      end else if (p2_ff[fsel_pkg::P2_RFU_BIT] ||
                   !(rsp_kind == fsel_pkg::RSP_FCP || rsp_kind == fsel_pkg::RSP_NONE)) begin
         bad_param = 1'b1;
      end else if (p1_ff == fsel_pkg::P1_BY_NAME && sess != fsel_pkg::SESS_ACTIVATE &&
                   sess != fsel_pkg::SESS_TERMINATE) begin
         bad_param = 1'b1;
      end
   end

   always_comb begin
      nxt_state = state_ff;     nxt_p1 = p1_ff;       nxt_p2 = p2_ff;
      nxt_lc = lc_ff;           nxt_le = le_ff;       nxt_le_pres = le_pres_ff;
      nxt_data_cnt = data_cnt_ff;
      nxt_key = key_ff;         nxt_stage = stage_ff; nxt_cls = cls_ff;
      nxt_cur_dir = cur_dir_ff; nxt_sel = sel_ff;     nxt_step = step_ff;
      nxt_sec = sec_ff;         nxt_hdr = hdr_ff;     nxt_pass = pass_ff;
      nxt_total = total_ff;     nxt_out_cnt = out_cnt_ff;
      nxt_olen = olen_ff;       nxt_part = part_ff;   nxt_tag = tag_ff;
      nxt_idx = idx_ff;         nxt_sw = sw_ff;       nxt_scope = scope_ff;
      nxt_rsp_b = rsp_b_ff;
      nxt_req = 1'b0;  nxt_rsp_v = 1'b0;  nxt_sw_v = 1'b0;
      nxt_ss = 1'b0;   nxt_se = 1'b0;     nxt_inv = 1'b0;
      commit = 1'b0;   c_cls = fsel_pkg::CLS_MF;  c_ref = fsel_pkg::MF_REF;
      emit_en = 1'b0;  emit_byte = 8'h00;
      case (state_ff)
         S_IDLE: begin
            if (CMD_VALID) begin
               nxt_p1 = CMD_P1;  nxt_p2 = CMD_P2;  nxt_lc = CMD_LC;
               nxt_le = CMD_LE;  nxt_le_pres = CMD_LE_PRESENT;
               nxt_data_cnt = 8'h00;
               nxt_stage = 2'h0;
               nxt_state = (CMD_LC == 8'h00) ? S_LOOK : S_DATA;
            end
         end
         S_DATA: begin
            if (DATA_VALID) begin
               // Bytes past the key store are consumed but dropped; Lc check answers later.
               if (data_cnt_ff < 8'(fsel_pkg::KEY_BYTES)) begin
                  nxt_key[data_cnt_ff[3:0]] = DATA_BYTE;
               end
               nxt_data_cnt = data_cnt_ff + 8'h01;
               if (nxt_data_cnt == lc_ff) begin
                  nxt_state = S_LOOK;
               end
            end
         end
         S_LOOK: begin
            if (bad_param) begin
               nxt_sw = fsel_pkg::SW_BAD_P1P2;
               nxt_state = S_STAT;
            end else if (lc_ff > 8'(fsel_pkg::KEY_BYTES)) begin
               nxt_sw = fsel_pkg::SW_BAD_LC;
               nxt_state = S_STAT;
            end else if (p1_ff == fsel_pkg::P1_BY_FID && lc_ff == 8'h00) begin
               commit = 1'b1;
            end else begin
               nxt_req = 1'b1;
               case (p1_ff)
                  fsel_pkg::P1_BY_FID:    nxt_scope = (stage_ff == 2'h0) ? fsel_pkg::SC_CHILD_CUR :
                                                      (stage_ff == 2'h1) ? fsel_pkg::SC_PARENT :
                                                      fsel_pkg::SC_CHILD_PARENT;
                  fsel_pkg::P1_CHILD_DF:  nxt_scope = fsel_pkg::SC_CHILD_DF;
                  fsel_pkg::P1_PARENT_DF: nxt_scope = fsel_pkg::SC_PARENT;
                  fsel_pkg::P1_BY_NAME:   nxt_scope = fsel_pkg::SC_NAME;
                  fsel_pkg::P1_PATH_MF:   nxt_scope = fsel_pkg::SC_PATH_MF;
                  default:                nxt_scope = fsel_pkg::SC_PATH_CUR;
               endcase
               nxt_state = S_LWAIT;
            end
         end
         S_LWAIT: begin
            if (LOOKUP_DONE) begin
               if (LOOKUP_FOUND) begin
                  commit = 1'b1;
                  c_cls = fsel_pkg::file_class_t'(LOOKUP_CLASS);
                  c_ref = LOOKUP_REF;
               end else if (p1_ff == fsel_pkg::P1_BY_FID && stage_ff != 2'h2) begin
                  nxt_stage = stage_ff + 2'h1;
                  nxt_state = S_LOOK;
               end else begin
                  nxt_sw = fsel_pkg::SW_NOT_FOUND;
                  nxt_state = S_STAT;
               end
            end
         end
         S_OREQ: begin
            if (step_ff == fsel_pkg::OBJ_STEPS) begin
               nxt_step = 4'h0;
               nxt_sec = 2'h0;
               if (!pass_ff) begin
                  // The length must lead the content, so a sizing pass runs first.
                  nxt_pass = 1'b1;
                  nxt_hdr = 2'h0;
                  nxt_state = S_HDR;
               end else begin
                  nxt_sw = fsel_pkg::SW_OK;
                  nxt_state = S_STAT;
               end
            end else if (ord_skip) begin
               nxt_step = step_ff + 4'h1;
            end else begin
               nxt_tag = ord_tag;
               nxt_idx = 8'h00;
               nxt_state = S_OWAIT;
            end
         end
         S_OWAIT: nxt_state = S_OEVAL;
         S_OEVAL: begin
            nxt_state = S_OREQ;
            if (!OBJ_PRESENT) begin
               if (ord_sec && sec_ff != 2'h2) begin
                  nxt_sec = sec_ff + 2'h1;
               end else begin
                  nxt_step = step_ff + 4'h1;
                  nxt_sec = 2'h0;
               end
            end else if (!pass_ff) begin
               nxt_total = total_ff + 9'(OBJ_LEN) + 9'h002;
               nxt_step = step_ff + 4'h1;
               nxt_sec = 2'h0;
            end else begin
               nxt_olen = OBJ_LEN;
               nxt_part = 8'h00;
               nxt_state = S_BYTE;
            end
         end
         S_HDR: begin
            emit_en = 1'b1;
            case (hdr_ff)
               2'h0: begin
                  emit_byte = fsel_pkg::TAG_FCP;
                  nxt_hdr = (total_ff > 9'(fsel_pkg::SHORT_LEN_MAX)) ? 2'h1 : 2'h2;
               end
               2'h1: begin
                  emit_byte = fsel_pkg::TAG_LEN_EXT;
                  nxt_hdr = 2'h2;
               end
               default: begin
                  emit_byte = total_ff[7:0];
                  nxt_state = S_OREQ;
               end
            endcase
         end
         S_BWAIT: nxt_state = S_BYTE;
         S_BYTE: begin
            emit_en = 1'b1;
            nxt_part = part_ff + 8'h01;
            if (part_ff == 8'h00) begin
               emit_byte = tag_ff;
            end else begin
               emit_byte = (part_ff == 8'h01) ? olen_ff : OBJ_BYTE;
               if (part_ff != 8'h01) begin
                  nxt_idx = idx_ff + 8'h01;
               end
               if (part_ff == olen_ff + 8'h01) begin
                  nxt_step = step_ff + 4'h1;
                  nxt_sec = 2'h0;
                  nxt_state = S_OREQ;
               end else begin
                  nxt_state = S_BWAIT;
               end
            end
         end
         S_STAT: begin
            nxt_sw_v = 1'b1;
            nxt_state = S_IDLE;
         end
         default: nxt_state = S_IDLE;
      endcase
      if (commit) begin
         nxt_cls = c_cls;
         nxt_sel = c_ref;
         if (c_cls != fsel_pkg::CLS_EF) begin
            nxt_cur_dir = c_ref;
         end
         nxt_inv = 1'b1;
         if (p1_ff == fsel_pkg::P1_BY_NAME) begin
            nxt_ss = (sess == fsel_pkg::SESS_ACTIVATE);
            nxt_se = (sess == fsel_pkg::SESS_TERMINATE);
         end
         if (rsp_kind == fsel_pkg::RSP_NONE) begin
            nxt_sw = fsel_pkg::SW_OK;
            nxt_state = S_STAT;
         end else begin
            nxt_step = 4'h0;  nxt_sec = 2'h0;  nxt_pass = 1'b0;
            nxt_total = 9'h000;
            nxt_out_cnt = 9'h000;
            nxt_state = S_OREQ;
         end
      end
      if (emit_en) begin
         // Output stops silently at Le; the status is still success.
         if (limited && out_cnt_ff == {1'b0, le_ff}) begin
            nxt_sw = fsel_pkg::SW_OK;
            nxt_state = S_STAT;
         end else begin
            nxt_rsp_v = 1'b1;
            nxt_rsp_b = emit_byte;
            nxt_out_cnt = out_cnt_ff + 9'h001;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         state_ff <= S_IDLE;  p1_ff <= 8'h00;  p2_ff <= 8'h00;  lc_ff <= 8'h00;
         le_ff <= 8'h00;      le_pres_ff <= 1'b0;  data_cnt_ff <= 8'h00;
         key_ff <= '{default: 8'h00};
         stage_ff <= 2'h0;    cls_ff <= fsel_pkg::CLS_MF;
         cur_dir_ff <= fsel_pkg::MF_REF;  sel_ff <= fsel_pkg::MF_REF;
         step_ff <= 4'h0;     sec_ff <= 2'h0;  hdr_ff <= 2'h0;  pass_ff <= 1'b0;
         total_ff <= 9'h000;  out_cnt_ff <= 9'h000;  olen_ff <= 8'h00;
         part_ff <= 8'h00;    tag_ff <= 8'h00;  idx_ff <= 8'h00;
         req_ff <= 1'b0;      rsp_v_ff <= 1'b0;  sw_v_ff <= 1'b0;
         rsp_b_ff <= 8'h00;   sw_ff <= 16'h0000;
         ss_ff <= 1'b0;       se_ff <= 1'b0;  inv_ff <= 1'b0;
         scope_ff <= fsel_pkg::SC_CHILD_CUR;
         busy_ff <= 1'b0;     pfx_ff <= 1'b0;  occ_ff <= 2'h0;
      end else begin
         state_ff <= nxt_state;  p1_ff <= nxt_p1;  p2_ff <= nxt_p2;  lc_ff <= nxt_lc;
         le_ff <= nxt_le;        le_pres_ff <= nxt_le_pres;  data_cnt_ff <= nxt_data_cnt;
         key_ff <= nxt_key;
         stage_ff <= nxt_stage;  cls_ff <= nxt_cls;
         cur_dir_ff <= nxt_cur_dir;  sel_ff <= nxt_sel;
         step_ff <= nxt_step;    sec_ff <= nxt_sec;  hdr_ff <= nxt_hdr;  pass_ff <= nxt_pass;
         total_ff <= nxt_total;  out_cnt_ff <= nxt_out_cnt;  olen_ff <= nxt_olen;
         part_ff <= nxt_part;    tag_ff <= nxt_tag;  idx_ff <= nxt_idx;
         req_ff <= nxt_req;      rsp_v_ff <= nxt_rsp_v;  sw_v_ff <= nxt_sw_v;
         rsp_b_ff <= nxt_rsp_b;  sw_ff <= nxt_sw;
         ss_ff <= nxt_ss;        se_ff <= nxt_se;  inv_ff <= nxt_inv;
         scope_ff <= nxt_scope;
         busy_ff <= (nxt_state != S_IDLE);  pfx_ff <= (nxt_scope == fsel_pkg::SC_NAME);
         occ_ff <= nxt_occ;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < fsel_pkg::KEY_BYTES; gi++) begin : g_key
         assign LOOKUP_KEY[8*gi +: 8] = key_ff[gi];
      end
   endgenerate

   // The occurrence field is forced to zero outside selection by name.
   always_comb begin
      nxt_occ = 2'h0;
      if (nxt_p1 == fsel_pkg::P1_BY_NAME) begin
         nxt_occ = nxt_p2[fsel_pkg::P2_OCC_MSB:fsel_pkg::P2_OCC_LSB];
      end
   end

   assign CMD_BUSY       = busy_ff;
   assign LOOKUP_OCC     = occ_ff;
   assign LOOKUP_REQ     = req_ff;
   assign LOOKUP_SCOPE   = scope_ff;
   assign LOOKUP_PREFIX  = pfx_ff;
   assign LOOKUP_KEY_LEN = lc_ff[4:0];
   assign CUR_DIR        = cur_dir_ff;
   assign SEL_FILE       = sel_ff;
   assign OBJ_TAG        = tag_ff;
   assign OBJ_IDX        = idx_ff;
   assign RSP_VALID      = rsp_v_ff;
   assign RSP_BYTE       = rsp_b_ff;
   assign SW_VALID       = sw_v_ff;
   assign SW             = sw_ff;
   assign SESSION_START  = ss_ff;
   assign SESSION_END    = se_ff;
   assign PTR_INVALIDATE = inv_ff;

endmodule

// File: fsel_store_model.sv
// Behavioural file store that answers lookups and object queries.
module fsel_store_model (
   input  wire logic       CORE_CLK,
   input  wire logic       LOOKUP_REQ,
   input  wire logic [2:0] LOOKUP_SCOPE,
   input  wire logic [7:0] OBJ_TAG,
   input  wire logic [7:0] OBJ_IDX,
   input  wire logic [1:0] cls,
   input  wire logic [3:0] dly,
   input  wire logic [2:0] hit,
   output logic            LOOKUP_DONE,
   output logic            LOOKUP_FOUND,
   output logic [1:0]      LOOKUP_CLASS,
   output logic [7:0]      LOOKUP_REF,
   output logic            OBJ_PRESENT,
   output logic [7:0]      OBJ_LEN,
   output logic [7:0]      OBJ_BYTE
);
   logic [4:0] cnt = 5'h00;
   logic [2:0] scope = 3'h0;

   // Outside a lookup answer the result lines toggle so stale values are never trusted.
   always @(posedge CORE_CLK) begin
      LOOKUP_DONE <= 1'b0;
      LOOKUP_FOUND <= (LOOKUP_FOUND !== 1'b1);
      LOOKUP_CLASS <= ~LOOKUP_CLASS;
      LOOKUP_REF <= ~LOOKUP_REF;
      if (LOOKUP_REQ) begin
         cnt <= {1'b0, dly} + 5'h01;
         scope <= LOOKUP_SCOPE;
      end else if (cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
         if (cnt == 5'h01) begin
            LOOKUP_DONE <= 1'b1;
            LOOKUP_FOUND <= (scope >= hit);
            LOOKUP_CLASS <= cls;
            LOOKUP_REF <= {5'h08, scope};
         end
      end
   end

   // Security object 8B is absent, so the fallback to 8C is exercised.
   always @(posedge CORE_CLK) begin
      OBJ_PRESENT <= OBJ_TAG inside {8'h82, 8'h83, 8'h84, 8'hA5, 8'h8A, 8'h8C, 8'hC6, 8'h80};
      OBJ_LEN <= 8'h02;
      OBJ_BYTE <= OBJ_TAG ^ OBJ_IDX;
   end
endmodule

// File: file_select_command_decoder_sva.sv
// Port level assertions for the file selection command decoder.
module fsel_chk (
   input wire logic        CORE_CLK,
   input wire logic        RST_N,
   input wire logic        CMD_VALID,
   input wire logic [7:0]  CMD_P1,
   input wire logic [7:0]  CMD_P2,
   input wire logic [7:0]  CMD_LC,
   input wire logic        CMD_BUSY,
   input wire logic        LOOKUP_DONE,
   input wire logic        LOOKUP_FOUND,
   input wire logic        LOOKUP_REQ,
   input wire logic [2:0]  LOOKUP_SCOPE,
   input wire logic [1:0]  LOOKUP_OCC,
   input wire logic        LOOKUP_PREFIX,
   input wire logic [7:0]  CUR_DIR,
   input wire logic        RSP_VALID,
   input wire logic [7:0]  RSP_BYTE,
   input wire logic        SW_VALID,
   input wire logic [15:0] SW,
   input wire logic        SESSION_START,
   input wire logic        SESSION_END,
   input wire logic        PTR_INVALIDATE
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   logic take;
   logic first_ff;
   logic nxt_first;
   logic quiet_ff;
   logic nxt_quiet;
   assign take = CMD_VALID && !CMD_BUSY;
   always_comb begin
      nxt_first = take ? 1'b1 : (RSP_VALID ? 1'b0 : first_ff);
      nxt_quiet = take ? (CMD_P2[4:2] == 3'h3 || (CMD_P1 == 8'h00 && CMD_LC == 8'h00)) : quiet_ff;
   end
   always_ff @(posedge CORE_CLK) begin
      first_ff <= RST_N && nxt_first;
      quiet_ff <= RST_N && nxt_quiet;
   end
   AST_BAD_P1: assert property (take && !(CMD_P1 inside {8'h00, 8'h01, 8'h03, 8'h04, 8'h08, 8'h09})
      && CMD_LC == 8'h00 |-> ##3 SW_VALID && SW == 16'h6A86) else $error("bad method not refused");
   AST_MF_SEL: assert property (take && CMD_P1 == 8'h00 && CMD_P2 == 8'h0C && CMD_LC == 8'h00
      |-> ##2 PTR_INVALIDATE && CUR_DIR == 8'h00 ##1 SW_VALID && SW == 16'h9000) else $error("master file select");
   AST_PTR_OK: assert property (PTR_INVALIDATE |-> ##[1:1000] SW_VALID && SW == 16'h9000)
      else $error("pointer drop without success");
   AST_SESS: assert property (SESSION_START || SESSION_END |-> LOOKUP_PREFIX) else $error("session pulse");
   AST_OCC: assert property (LOOKUP_REQ && !LOOKUP_PREFIX |-> LOOKUP_OCC == 2'h0) else $error("occurrence");
   AST_PREFIX: assert property (LOOKUP_REQ |-> LOOKUP_PREFIX == (LOOKUP_SCOPE == 3'h4))
      else $error("prefix match flag");
   AST_SEARCH: assert property (LOOKUP_DONE && !LOOKUP_FOUND && LOOKUP_SCOPE == 3'h0
      |-> ##[1:4] LOOKUP_REQ && LOOKUP_SCOPE == 3'h1) else $error("search order");
   AST_TAG62: assert property (RSP_VALID && first_ff |-> RSP_BYTE == 8'h62) else $error("template tag");
   AST_QUIET: assert property (RSP_VALID |-> !quiet_ff) else $error("data when none asked");
endmodule

bind file_select_command_decoder fsel_chk u_chk (.*);

// File: test_file_select_command_decoder.sv
// Self-checking bench for the file selection command decoder.
module test_file_select_command_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   logic         CORE_CLK = 1'b0;
   logic         RST_N = 1'b0;
   logic         CMD_VALID = 1'b0;
   logic [7:0]   CMD_P1 = 8'h00;
   logic [7:0]   CMD_P2 = 8'h00;
   logic [7:0]   CMD_LC = 8'h00;
   logic         CMD_LE_PRESENT = 1'b1;
   logic [7:0]   CMD_LE = 8'h00;
   logic         DATA_VALID = 1'b0;
   logic [7:0]   DATA_BYTE = 8'h00;
   logic [1:0]   cls = 2'h0;
   logic [3:0]   dly = 4'h0;
   logic [2:0]   hit = 3'h0;
   logic         LOOKUP_DONE, LOOKUP_FOUND, OBJ_PRESENT, CMD_BUSY, LOOKUP_REQ, LOOKUP_PREFIX;
   logic         RSP_VALID, SW_VALID, SESSION_START, SESSION_END, PTR_INVALIDATE;
   logic [1:0]   LOOKUP_CLASS, LOOKUP_OCC;
   logic [7:0]   LOOKUP_REF, OBJ_LEN, OBJ_BYTE, CUR_DIR, SEL_FILE, OBJ_TAG, OBJ_IDX, RSP_BYTE, p1, p2, lc;
   logic [2:0]   LOOKUP_SCOPE;
   logic [127:0] LOOKUP_KEY;
   logic [4:0]   LOOKUP_KEY_LEN;
   logic [15:0]  SW;
   logic [31:0]  r = 32'hA970C3CD;
   logic [7:0]   lst [6] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h08, 8'h09};
   logic [7:0]   q[$];
   logic [7:0]   e[$];
   int           bad_count = 0;
   int           total_checks = 0;

   file_select_command_decoder dut (.*);
   fsel_store_model store (.*);

   initial forever #4 CORE_CLK = ~CORE_CLK;

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction
   function automatic logic bad_par(input logic [7:0] a, input logic [7:0] b);
      return !(a inside {8'h00, 8'h01, 8'h03, 8'h04, 8'h08, 8'h09}) || b[7] || !(b[4:2] inside {3'h1, 3'h3})
         || (a == 8'h04 && b[5]);
   endfunction
   // Last scope searched for each method; a plain identifier search ends on the parent's children.
   function automatic logic [2:0] scope_of(input logic [7:0] a);
      case (a)
         8'h01: return 3'h3;
         8'h03: return 3'h1;
         8'h04: return 3'h4;
         8'h08: return 3'h5;
         8'h09: return 3'h6;
         default: return 3'h2;
      endcase
   endfunction
   function automatic logic same;
      if (q.size() != e.size()) return 1'b0;
      foreach (q[i]) if (q[i] !== e[i]) return 1'b0;
      return 1'b1;
   endfunction

   task automatic wrap_up;
      if (bad_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (!ok) begin
         bad_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic build_exp;
      logic [7:0] t[$];
      if (cls == 2'h3) t = '{8'h82, 8'h83, 8'hA5, 8'h8A, 8'h8C, 8'h80};
      else t = '{8'h82, 8'h83, 8'h84, 8'hA5, 8'h8A, 8'h8C, 8'hC6};
      e = '{8'h62, 8'h00};
      foreach (t[i]) if (t[i] != 8'h84 || cls == 2'h2) e = {e, t[i], 8'h02, t[i], t[i] ^ 8'h01};
      e[1] = 8'(e.size() - 2);
   endtask
   task automatic do_cmd(input logic [7:0] a, input logic [7:0] b, input logic [7:0] n_lc);
      logic [15:0] xsw;
      int n;
      int ns = 0;
      int np = 0;
      q = {};
      n = 0;
      @(posedge CORE_CLK);
      xsw = bad_par(a, b) ? 16'h6A86 : (n_lc > 8'h10) ? 16'h6A87 : (a == 8'h00 && n_lc == 8'h00) ? 16'h9000
         : (scope_of(a) < hit) ? 16'h6A82 : 16'h9000;
      CMD_VALID <= 1'b1;
      CMD_P1 <= a;
      CMD_P2 <= b;
      CMD_LC <= n_lc;
      do begin
         @(posedge CORE_CLK);
         CMD_VALID <= 1'b0;
         DATA_VALID <= (n < n_lc);
         DATA_BYTE <= r[7:0];
         r = lfsr(r);
         #1;
         if (RSP_VALID === 1'b1) q.push_back(RSP_BYTE);
         if (LOOKUP_REQ === 1'b1) chk(LOOKUP_OCC === (a == 8'h04 ? b[1:0] : 2'h0), "occurrence");
         ns += (SESSION_START === 1'b1) + 2 * (SESSION_END === 1'b1);
         np += (PTR_INVALIDATE === 1'b1);
         n++;
      end while (SW_VALID !== 1'b1 && n < 2000);
      if (SW_VALID !== 1'b1) begin
         bad_count++;
         wrap_up;
      end
      chk(SW === xsw, "status word");
      chk(np == (xsw == 16'h9000), "pointer drop count");
      chk(ns == ((a == 8'h04 && xsw == 16'h9000) ? (b[6] ? 2 : 1) : 0), "session pulse");
      if (xsw == 16'h9000 && b[4:2] == 3'h1 && !(a == 8'h00 && n_lc == 8'h00)) build_exp;
      else e = {};
      while (CMD_LE != 8'h00 && e.size() > CMD_LE) e.pop_back();
      chk(same(), "response bytes");
   endtask

   initial begin
      repeat (2) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      do_cmd(8'h00, 8'h0C, 8'h00);
      chk(CUR_DIR === 8'h00 && SEL_FILE === 8'h00, "master file not current");
      hit <= 3'h2;
      do_cmd(8'h00, 8'h04, 8'h02);
      cls <= 2'h2;
      do_cmd(8'h04, 8'h44, 8'h05);
      do_cmd(8'h04, 8'h27, 8'h05);
      do_cmd(8'h02, 8'h04, 8'h00);
      do_cmd(8'h03, 8'h0C, 8'h00);
      for (int k = 0; k < 40; k++) begin
         r = lfsr(r);
         p1 = (r[2:0] < 3'h6) ? lst[r[2:0]] : r[15:8];
         p2 = r[16] ? r[31:24] : {1'b0, r[22:21], 1'b0, r[20], 1'b1, r[19:18] & {2{p1 == 8'h04}}};
         lc = {3'h0, r[27:23]};
         if (p1 == 8'h00 && lc == 8'h00) p2 = 8'h0C;
         cls <= r[29:28];
         dly <= r[11:8];
         hit <= {r[30], 2'h0};
         CMD_LE <= {2'h0, r[7:3], 1'b0};
         do_cmd(p1, p2, lc);
      end
      wrap_up;
   end
endmodule
